/* tb/eicf_bench.sv */
// Bench: self-checking scenarios for the interrupt block
`timescale 1ns/1ps
module eicf_bench;
  import eicf_pkg::*;
  logic       clk_sys_i = 1'h0, rst_n_i = 1'h0, io_wr_i = 1'h0, io_rd_i = 1'h0;
  logic       ext_a_pin_i = 1'h1, ext_b_pin_i = 1'h1, tov_event_i = 1'h0;
  logic       set_glb = 1'h0, stall = 1'h0; // Core model controls
  logic       global_en_i, core_ready_i, irq_take_o, vec_valid_o;
  logic [5:0] io_addr_i = 6'h00;
  logic [7:0] io_wdata_i = 8'h00, port_in_i = 8'hff, alt_func_i = 8'h00, io_rdata_o, vec_cnt;
  logic [9:0] vec_addr_o, last_vec;
  int         num_errors = 0, comparisons = 0;
  always #4 clk_sys_i = ~clk_sys_i; // 125 MHz
  eicf_top DUT (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .ext_a_pin_i(ext_a_pin_i), .ext_b_pin_i(ext_b_pin_i), .port_in_i(port_in_i),
    .alt_func_i(alt_func_i), .tov_event_i(tov_event_i), .global_en_i(global_en_i),
    .core_ready_i(core_ready_i), .irq_take_o(irq_take_o), .vec_valid_o(vec_valid_o),
    .vec_addr_o(vec_addr_o));
  eicf_core_model u_core (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .set_glb_i(set_glb), .stall_i(stall),
    .irq_take_i(irq_take_o), .vec_valid_i(vec_valid_o), .vec_addr_i(vec_addr_o),
    .global_en_o(global_en_i), .core_ready_o(core_ready_i), .last_vec_o(last_vec),
    .vec_cnt_o(vec_cnt));
  task automatic end_of_test();
    $display("Errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'h1;
    step(1);
    io_wr_i = 1'h0;
    step(1); // Strobe low for one edge before any next write
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    io_addr_i = a;
    io_rd_i = 1'h1;
    step(1);
    io_rd_i = 1'h0;
    step(1);
    check({2'h0, io_rdata_o}, {2'h0, exp});
  endtask
  task automatic glb();
    set_glb = 1'h1;
    step(1);
    set_glb = 1'h0;
  endtask
  task automatic set_pin(input int p, input logic v);
    if (p == 1) ext_b_pin_i = v;
    else ext_a_pin_i = v;
  endtask
  task automatic expect_vec(input logic [9:0] exp);
    logic [7:0] c0;
    c0 = vec_cnt;
    repeat (40) if (vec_cnt === c0) step(1);
    if (vec_cnt === c0) begin
      num_errors++;
      end_of_test();
    end
    check(last_vec, exp);
  endtask
  task automatic expect_none(input int n);
    logic [7:0] c0;
    c0 = vec_cnt;
    step(n);
    check({2'h0, vec_cnt}, {2'h0, c0});
  endtask
  // Reset values, unmapped place, control readback
  task automatic t_regs();
    rd_chk(EICF_CTRL_ADDR, EICF_CTRL_RST);
    rd_chk(EICF_FLAGS_ADDR, EICF_FLAGS_RST);
    wr(6'h01, 8'hff);
    rd_chk(6'h01, 8'h00);
    wr(EICF_CTRL_ADDR, 8'h0f);
    rd_chk(EICF_CTRL_ADDR, 8'h0f);
  endtask
  // Wrong edge, write-zero, write-one, right pulse, per pin and edge mode
  task automatic t_edges();
    logic       lvl;
    logic [7:0] fbit;
    for (int p = 0; p < 2; p++) begin
      for (int m = 1; m < 4; m++) begin
        lvl = (m == 3);
        fbit = p ? 8'h80 : 8'h40;
        set_pin(p, lvl);
        wr(EICF_CTRL_ADDR, p ? {4'h0, m[1:0], 2'h0} : {6'h00, m[1:0]});
        step(4);
        wr(EICF_FLAGS_ADDR, 8'hff);
        set_pin(p, !lvl);
        step(4);
        rd_chk(EICF_FLAGS_ADDR, (m == 1) ? fbit : 8'h00);
        wr(EICF_FLAGS_ADDR, 8'h00);
        rd_chk(EICF_FLAGS_ADDR, (m == 1) ? fbit : 8'h00);
        wr(EICF_FLAGS_ADDR, fbit);
        rd_chk(EICF_FLAGS_ADDR, 8'h00);
        set_pin(p, lvl);
        step(2);
        set_pin(p, !lvl);
        step(4);
        rd_chk(EICF_FLAGS_ADDR, fbit);
      end
    end
    wr(EICF_CTRL_ADDR, 8'h00);
    step(2);
    rd_chk(EICF_FLAGS_ADDR, 8'h00);
  endtask
  // Latched flags wait for global, then lower vector first
  task automatic t_prio();
    ext_b_pin_i = 1'h1;
    step(4);
    wr(EICF_CTRL_ADDR, 8'h08);
    wr(EICF_FLAGS_ADDR, 8'hff);
    ext_b_pin_i = 1'h0;
    tov_event_i = 1'h1;
    step(1);
    tov_event_i = 1'h0;
    step(4);
    rd_chk(EICF_FLAGS_ADDR, 8'h90);
    wr(EICF_CTRL_ADDR, 8'h98);
    expect_none(10);
    glb();
    expect_vec(EICF_VEC_B);
    rd_chk(EICF_FLAGS_ADDR, 8'h10);
    glb();
    expect_vec(EICF_VEC_TOV);
    rd_chk(EICF_FLAGS_ADDR, 8'h00);
  endtask
  // Level mode requests while low, never latched
  task automatic t_low_a();
    ext_a_pin_i = 1'h1; // Pin left low by the edge scenarios
    wr(EICF_CTRL_ADDR, 8'h40);
    glb();
    expect_none(8);
    ext_a_pin_i = 1'h0;
    expect_vec(EICF_VEC_A);
    glb();
    expect_vec(EICF_VEC_A);
    ext_a_pin_i = 1'h1;
    step(4);
    glb();
    expect_none(10);
  endtask
  // Port low-level request, masked pins, core stall
  task automatic t_ll();
    wr(EICF_CTRL_ADDR, 8'h20);
    alt_func_i = 8'h04;
    port_in_i = 8'hfb;
    expect_none(10);
    stall = 1'h1;
    alt_func_i = 8'h00;
    expect_none(10);
    stall = 1'h0;
    expect_vec(EICF_VEC_LL);
    port_in_i = 8'hff;
    step(4);
    glb();
    expect_none(10);
  endtask
  // Edge flags vector, first before second, vector clears flag
  task automatic t_edge_vec();
    ext_b_pin_i = 1'h1;
    wr(EICF_CTRL_ADDR, 8'h0a);
    step(4);
    wr(EICF_FLAGS_ADDR, 8'hff);
    ext_a_pin_i = 1'h0;
    ext_b_pin_i = 1'h0;
    step(4);
    rd_chk(EICF_FLAGS_ADDR, 8'hc0);
    wr(EICF_CTRL_ADDR, 8'hca);
    expect_vec(EICF_VEC_A);
    rd_chk(EICF_FLAGS_ADDR, 8'h80);
    glb();
    expect_vec(EICF_VEC_B);
    rd_chk(EICF_FLAGS_ADDR, 8'h00);
  endtask
  initial begin
    step(4);
    rst_n_i = 1'h1;
    step(2);
    t_regs();
    t_edges();
    t_prio();
    t_low_a();
    t_ll();
    t_edge_vec();
    end_of_test();
  end
endmodule // eicf_bench

/* tb/eicf_checker.sv */
// Checker: port assertions of the interrupt block
`timescale 1ns/1ps
module eicf_checker
  import eicf_pkg::*;
#(
  parameter int RESP_CYC = EICF_RESP_CYC // Accept-to-vector cycles
) (
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic [5:0] io_addr_i,
  input wire logic       io_wr_i,
  input wire logic       io_rd_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic       global_en_i,
  input wire logic       core_ready_i,
  input wire logic       irq_take_o,
  input wire logic       vec_valid_o,
  input wire logic [9:0] vec_addr_o
);
  // ***************************************************
  // Control mirror and properties
  // ***************************************************
  localparam int GAP    = RESP_CYC;     // Take pulse to vector pulse
  localparam int TAKE_D = RESP_CYC + 1; // Vector pulse back to accept edge
  logic [7:0] ctrl_q;                // Control register mirror
  // Follow control writes
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) ctrl_q <= EICF_CTRL_RST;
    else if (io_wr_i && io_addr_i == EICF_CTRL_ADDR) ctrl_q <= io_wdata_i;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_flag_rd;
    io_rd_i && io_addr_i == EICF_FLAGS_ADDR;
  endsequence
  sequence s_vec(logic [9:0] v);
    vec_valid_o && vec_addr_o == v;
  endsequence
  a_take_to_vec:
    assert property (irq_take_o |-> ##GAP vec_valid_o) else $error("vector missing");
  a_take_gap:
    assert property (irq_take_o |=> !irq_take_o until vec_valid_o) else $error("accept while busy");
  a_take_needs_en:
    assert property (irq_take_o |-> $past(global_en_i && core_ready_i)
      && $past(ctrl_q[7:4]) != 4'h0) else $error("accept without enables");
  a_first_vec_gated:
    assert property (s_vec(EICF_VEC_A) |-> $past(ctrl_q[EICF_A_EN_BIT], TAKE_D))
      else $error("first vector while disabled");
  a_second_vec_gated:
    assert property (s_vec(EICF_VEC_B) |-> $past(ctrl_q[EICF_B_EN_BIT], TAKE_D))
      else $error("second vector while disabled");
  a_tov_vec_gated:
    assert property (s_vec(EICF_VEC_TOV) |-> $past(ctrl_q[EICF_TOV_EN_BIT], TAKE_D))
      else $error("timer vector while disabled");
  a_flags_reserved_zero:
    assert property (s_flag_rd |=> (io_rdata_o & 8'h2f) == 8'h00) else $error("reserved set");
  a_low_flag_zero:
    assert property (s_flag_rd ##0 (ctrl_q[1:0] == EICF_SNS_LOW
      && $past(ctrl_q[1:0]) == EICF_SNS_LOW) |=> !io_rdata_o[EICF_A_FLAG_BIT])
      else $error("edge flag set in level mode");
  a_b_low_flag:
    assert property (s_flag_rd ##0 (ctrl_q[3:2] == EICF_SNS_LOW
      && $past(ctrl_q[3:2]) == EICF_SNS_LOW) |=> !io_rdata_o[EICF_B_FLAG_BIT])
      else $error("second edge flag set in level mode");
endmodule // eicf_checker

bind eicf_top eicf_checker #(.RESP_CYC(RESP_CYC)) u_eicf_checker (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
  .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
  .global_en_i(global_en_i), .core_ready_i(core_ready_i), .irq_take_o(irq_take_o),
  .vec_valid_o(vec_valid_o), .vec_addr_o(vec_addr_o));

/* tb/eicf_core_model.sv */
// Model: processor core taking vectors from the interrupt block
`timescale 1ns/1ps
module eicf_core_model (
  input  wire logic       clk_sys_i,    // System clock
  input  wire logic       rst_n_i,      // Synchronous reset, active low
  input  wire logic       set_glb_i,    // Software sets global enable
  input  wire logic       stall_i,      // Long instruction running
  input  wire logic       irq_take_i,   // Accept pulse
  input  wire logic       vec_valid_i,  // Vector presented
  input  wire logic [9:0] vec_addr_i,   // Vector address
  output logic            global_en_o,  // Global enable bit
  output logic            core_ready_o, // At instruction boundary
  output logic      [9:0] last_vec_o,   // Last vector taken
  output logic      [7:0] vec_cnt_o     // Vectors taken
);
  assign core_ready_o = !stall_i; // Boundary unless stalled
  // Accept clears global enable, software sets it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) global_en_o <= 1'h0;
    else if (irq_take_i) global_en_o <= 1'h0;
    else if (set_glb_i) global_en_o <= 1'h1;
  end
  // Count vectors jumped to
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) vec_cnt_o <= 8'h00;
    else if (vec_valid_i) vec_cnt_o <= vec_cnt_o + 8'h01;
  end
  // Keep the last vector
  always_ff @(posedge clk_sys_i) begin
    if (vec_valid_i) last_vec_o <= vec_addr_i;
  end
endmodule // eicf_core_model

/* verilog/eicf_edge_det.sv */
// Module: trigger detector for one synchronised external pin
`timescale 1ns/1ps
module eicf_edge_det
  import eicf_pkg::*;
(
  input  wire logic clk_sys_i, // System clock
  input  wire logic rst_n_i,   // Synchronous reset, active low
  eicf_sense_if.det sns        // Sense settings and answer
);

  // ***************************************************
  // Previous level and decode
  // ***************************************************
  logic prev_q; // Level one cycle ago

  // Hold last sampled level; reset as idle high
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= sns.pin_sync;
    end
  end

  // Decode the two-bit trigger select
  always_comb begin
    sns.level_req = 1'b0;
    sns.edge_hit  = 1'b0;
    unique case (sns.sense)
      EICF_SNS_LOW:  sns.level_req = !sns.pin_sync;            // Level
      EICF_SNS_ANY:  sns.edge_hit  = sns.pin_sync ^ prev_q;     // Change
      EICF_SNS_FALL: sns.edge_hit  = prev_q & !sns.pin_sync;    // Falling
      EICF_SNS_RISE: sns.edge_hit  = !prev_q & sns.pin_sync;    // Rising
    endcase
  end

endmodule // eicf_edge_det

/* verilog/eicf_if.sv */
// Interface: one external pin's sense settings and detector answer
`timescale 1ns/1ps
interface eicf_sense_if;
  logic [1:0] sense;     // Selected trigger
  logic       pin_sync;  // Synchronised pin level
  logic       level_req; // Low-level request
  logic       edge_hit;  // Qualifying edge seen, one cycle

  modport ctl (output sense, output pin_sync, input level_req, input edge_hit);
  modport det (input sense, input pin_sync, output level_req, output edge_hit);
endinterface

/* verilog/eicf_pkg.sv */
// Package: offsets, field positions, encodings and vectors of the interrupt block
package eicf_pkg;

  // ***************************************************
  // Register map (I/O space byte offsets)
  // ***************************************************
  localparam logic [5:0] EICF_CTRL_ADDR  = 6'h06; // Interrupt control register
  localparam logic [5:0] EICF_FLAGS_ADDR = 6'h3a; // Interrupt flag register (chosen)
  localparam logic [7:0] EICF_CTRL_RST   = 8'h00; // Control reset value
  localparam logic [7:0] EICF_FLAGS_RST  = 8'h00; // Flags reset value

  // ***************************************************
  // Control field positions
  // ***************************************************
  localparam int EICF_B_EN_BIT   = 7; // Second external enable
  localparam int EICF_A_EN_BIT   = 6; // First external enable
  localparam int EICF_LL_EN_BIT  = 5; // Low-level input enable
  localparam int EICF_TOV_EN_BIT = 4; // Timer overflow enable
  localparam int EICF_B_SNS_HI   = 3; // Second sense field, upper bit
  localparam int EICF_B_SNS_LO   = 2; // Second sense field, lower bit
  localparam int EICF_A_SNS_HI   = 1; // First sense field, upper bit
  localparam int EICF_A_SNS_LO   = 0; // First sense field, lower bit

  // ***************************************************
  // Flag field positions
  // ***************************************************
  localparam int EICF_B_FLAG_BIT   = 7; // Second external flag
  localparam int EICF_A_FLAG_BIT   = 6; // First external flag
  localparam int EICF_TOV_FLAG_BIT = 4; // Timer overflow flag

  // ***************************************************
  // Sense encodings
  // ***************************************************
  localparam logic [1:0] EICF_SNS_LOW  = 2'h0; // Low level
  localparam logic [1:0] EICF_SNS_ANY  = 2'h1; // Any change
  localparam logic [1:0] EICF_SNS_FALL = 2'h2; // Falling edge
  localparam logic [1:0] EICF_SNS_RISE = 2'h3; // Rising edge

  // ***************************************************
  // Vector addresses and response time
  // ***************************************************
  localparam logic [9:0] EICF_VEC_NONE = 10'h000; // No request
  localparam logic [9:0] EICF_VEC_A    = 10'h001; // First external
  localparam logic [9:0] EICF_VEC_B    = 10'h002; // Second external
  localparam logic [9:0] EICF_VEC_LL   = 10'h003; // Low-level input
  localparam logic [9:0] EICF_VEC_TOV  = 10'h004; // Timer overflow
  localparam int         EICF_RESP_CYC = 4;       // Least cycles accept to vector

endpackage

/* verilog/eicf_top.sv */
// Module: external, low-level and timer interrupt control with flags
`timescale 1ns/1ps
module eicf_top
  import eicf_pkg::*;
#(
  parameter int RESP_CYC = EICF_RESP_CYC // Accept-to-vector cycles
) (
  input  wire logic       clk_sys_i,     // System clock
  input  wire logic       rst_n_i,       // Synchronous reset, active low
  input  wire logic [5:0] io_addr_i,     // I/O register address
  input  wire logic       io_wr_i,       // Write strobe
  input  wire logic       io_rd_i,       // Read strobe
  input  wire logic [7:0] io_wdata_i,    // Write data
  output logic      [7:0] io_rdata_o,    // Registered read data
  input  wire logic       ext_a_pin_i,   // First external pin
  input  wire logic       ext_b_pin_i,   // Second external pin
  input  wire logic [7:0] port_in_i,     // Input port pins
  input  wire logic [7:0] alt_func_i,    // Pins in alternate use
  input  wire logic       tov_event_i,   // Timer overflow pulse
  input  wire logic       global_en_i,   // Core global enable bit
  input  wire logic       core_ready_i,  // Core may take an interrupt
  output logic            irq_take_o,    // Accept pulse: clear global
  output logic            vec_valid_o,   // Vector presented, one cycle
  output logic      [9:0] vec_addr_o     // Vector address
);

  // ***************************************************
  // Registers and synchronisers
  // ***************************************************
  logic [7:0] ctrl_q;          // Control register
  logic       flag_a_q;        // First external flag
  logic       flag_b_q;        // Second external flag
  logic       flag_tov_q;      // Timer overflow flag
  logic [1:0] a_meta_q;        // First pin sync chain
  logic [1:0] b_meta_q;        // Second pin sync chain
  logic [7:0] port_meta_q;     // Port first stage
  logic [7:0] port_sync_q;     // Port second stage
  logic [9:0] pend_vec_q;      // Vector being served
  logic [2:0] resp_cnt_q;      // Response countdown

  typedef enum logic [1:0] {EICF_IDLE, EICF_WAIT, EICF_VEC} eicf_state_e;
  eicf_state_e state_q;        // Response sequencer

  eicf_sense_if sa ();         // First pin detector link
  eicf_sense_if sb ();         // Second pin detector link

  // Two-stage pin synchronisers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      a_meta_q    <= 2'h3;
      b_meta_q    <= 2'h3;
      port_meta_q <= 8'hff;
      port_sync_q <= 8'hff;
    end else begin
      a_meta_q    <= {a_meta_q[0], ext_a_pin_i};
      b_meta_q    <= {b_meta_q[0], ext_b_pin_i};
      port_meta_q <= port_in_i;
      port_sync_q <= port_meta_q;
    end
  end

  // Sense fields feed the detectors
  assign sa.sense    = ctrl_q[EICF_A_SNS_HI:EICF_A_SNS_LO];
  assign sb.sense    = ctrl_q[EICF_B_SNS_HI:EICF_B_SNS_LO];
  assign sa.pin_sync = a_meta_q[1];
  assign sb.pin_sync = b_meta_q[1];

  eicf_edge_det u_det_a (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .sns       (sa.det)
  );

  eicf_edge_det u_det_b (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .sns       (sb.det)
  );

  // ***************************************************
  // Request qualification
  // ***************************************************
  logic wr_ctrl;   // Control write
  logic wr_flags;  // Flag write
  logic ll_any;    // Any unmasked port pin low
  logic req_a;     // First external request
  logic req_b;     // Second external request
  logic req_ll;    // Low-level request
  logic req_tov;   // Timer request
  logic [9:0] win_vec; // Highest priority vector
  logic       take;    // Accept now
  logic clr_a;     // Vector clear, first flag
  logic clr_b;     // Vector clear, second flag
  logic clr_tov;   // Vector clear, timer flag

  assign wr_ctrl  = io_wr_i && (io_addr_i == EICF_CTRL_ADDR);
  assign wr_flags = io_wr_i && (io_addr_i == EICF_FLAGS_ADDR);
  assign ll_any   = |(~port_sync_q & ~alt_func_i);

  // Level mode is unlatched; edge mode goes through the flag
  assign req_a = global_en_i && ctrl_q[EICF_A_EN_BIT] &&
                 (sa.level_req || flag_a_q);
  assign req_b = global_en_i && ctrl_q[EICF_B_EN_BIT] &&
                 (sb.level_req || flag_b_q);
  assign req_ll  = global_en_i && ctrl_q[EICF_LL_EN_BIT] && ll_any;
  assign req_tov = global_en_i && ctrl_q[EICF_TOV_EN_BIT] && flag_tov_q;

  // Fixed priority, lower vector first
  always_comb begin
    if (req_a) begin
      win_vec = EICF_VEC_A;
    end else if (req_b) begin
      win_vec = EICF_VEC_B;
    end else if (req_ll) begin
      win_vec = EICF_VEC_LL;
    end else if (req_tov) begin
      win_vec = EICF_VEC_TOV;
    end else begin
      win_vec = EICF_VEC_NONE;
    end
  end

  assign take    = (state_q == EICF_IDLE) && core_ready_i && (win_vec != EICF_VEC_NONE);
  assign clr_a   = (state_q == EICF_VEC) && (pend_vec_q == EICF_VEC_A);
  assign clr_b   = (state_q == EICF_VEC) && (pend_vec_q == EICF_VEC_B);
  assign clr_tov = (state_q == EICF_VEC) && (pend_vec_q == EICF_VEC_TOV);

  // ***************************************************
  // Register file
  // ***************************************************
  // Control register write
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_q <= EICF_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= io_wdata_i;
    end
  end

  // Flags: set wins over clear; zero writes ignored; level mode forces zero
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      flag_a_q   <= 1'b0;
      flag_b_q   <= 1'b0;
      flag_tov_q <= 1'b0;
    end else begin
      if (sa.sense == EICF_SNS_LOW) begin
        flag_a_q <= 1'b0;
      end else if (sa.edge_hit) begin
        flag_a_q <= 1'b1;
      end else if (clr_a || (wr_flags && io_wdata_i[EICF_A_FLAG_BIT])) begin
        flag_a_q <= 1'b0;
      end
      if (sb.sense == EICF_SNS_LOW) begin
        flag_b_q <= 1'b0;
      end else if (sb.edge_hit) begin
        flag_b_q <= 1'b1;
      end else if (clr_b || (wr_flags && io_wdata_i[EICF_B_FLAG_BIT])) begin
        flag_b_q <= 1'b0;
      end
      if (tov_event_i) begin
        flag_tov_q <= 1'b1;
      end else if (clr_tov || (wr_flags && io_wdata_i[EICF_TOV_FLAG_BIT])) begin
        flag_tov_q <= 1'b0;
      end
    end
  end

  // Registered read port; reserved bits zero
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      io_rdata_o <= 8'h00;
    end else if (io_rd_i) begin
      if (io_addr_i == EICF_CTRL_ADDR) begin
        io_rdata_o <= ctrl_q;
      end else if (io_addr_i == EICF_FLAGS_ADDR) begin
        io_rdata_o <= {flag_b_q, flag_a_q, 1'b0, flag_tov_q, 4'h0};
      end else begin
        io_rdata_o <= 8'h00; // Unmapped reads zero
      end
    end
  end

  // ***************************************************
  // Response sequencer
  // ***************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q     <= EICF_IDLE;
      pend_vec_q  <= EICF_VEC_NONE;
      resp_cnt_q  <= 3'h0;
      irq_take_o  <= 1'b0;
      vec_valid_o <= 1'b0;
      vec_addr_o  <= EICF_VEC_NONE;
    end else begin
      irq_take_o  <= 1'b0;
      vec_valid_o <= 1'b0;
      unique case (state_q)
        EICF_IDLE: begin
          if (take) begin
            state_q    <= EICF_WAIT;
            pend_vec_q <= win_vec;
            resp_cnt_q <= 3'(RESP_CYC - 2);
            irq_take_o <= 1'b1;
          end
        end
        EICF_WAIT: begin
          if (resp_cnt_q == 3'h0) begin
            state_q <= EICF_VEC;
          end else begin
            resp_cnt_q <= resp_cnt_q - 3'h1;
          end
        end
        EICF_VEC: begin
          state_q     <= EICF_IDLE;
          vec_valid_o <= 1'b1;
          vec_addr_o  <= pend_vec_q;
        end
      endcase
    end
  end

endmodule // eicf_top
